// File: msv_defines.vh
`ifndef MSV_DEFINES_VH
`define MSV_DEFINES_VH

// Register byte offsets on the Wishbone bus.
`define MSV_CTRL 6'h00
`define MSV_SYSRES 6'h04
`define MSV_TESTPCT 6'h08
`define MSV_VMAX 6'h0c
`define MSV_RATING 6'h10
`define MSV_MAXTIME 6'h14
`define MSV_CBGAIN 6'h18
`define MSV_STSPEED 6'h1c
`define MSV_STDUTY 6'h20
`define MSV_STTIME 6'h24
`define MSV_MAINLIM 6'h28
`define MSV_STATUS 6'h2c
`define MSV_MASK 6'h30
`define MSV_STATE 6'h34

// Control and status field positions.
`define MSV_CTRL_AUTO 0
`define MSV_ST_STALL 0
`define MSV_ST_MAXT 1
`define MSV_ST_RDONE 2

// Accepted ranges.
`define MSV_RES_MAX 10'd800
`define MSV_TEST_MIN 10'd5
`define MSV_TEST_MAX 10'd50
`define MSV_VMAX_MIN 10'd20
`define MSV_VMAX_MAX 10'd27
`define MSV_MAXT_MAX 10'd120
`define MSV_PCT_MAX 10'd100
`define MSV_STT_MIN 10'd16
`define MSV_STT_MAX 10'd32
`define MSV_RATE_V0 7'd45
`define MSV_RATE_V1 7'd70
`define MSV_RATE_V2 7'd35

// Reset values.
`define MSV_RST_RES 10'h000
`define MSV_RST_TEST 6'h0a
`define MSV_RST_VMAX 5'h18
`define MSV_RST_RATING 7'h00
`define MSV_RST_MAXT 7'h3c
`define MSV_RST_CBGAIN 7'h32
`define MSV_RST_STSPEED 8'h00
`define MSV_RST_STDUTY 7'h00
`define MSV_RST_STTIME 6'h10
`define MSV_RST_MAINLIM 7'h2d

// Timing: one tick is 1 ms; cycles follow from the 100 MHz clock.
`define MSV_TICK_NS 1000000
`define MSV_CLK_NS 10
`define MSV_TICK_CYC (`MSV_TICK_NS / `MSV_CLK_NS)
`define MSV_MS_PER_S 1000
`define MSV_SETTLE_MS 100
`define MSV_CB_STEP_MA 17'd1

`endif

// File: msv_div.v
`timescale 1ns/100ps
// Restoring serial divider, one quotient bit per clock.
module msv_div #(
   parameter NW = 26,
   parameter DW = 16
)(
   input wire clk_i,
   input wire rst_i,
   input wire start_i,
   input wire [NW-1:0] num_i,
   input wire [DW-1:0] den_i,
   output reg busy_o,
   output reg done_o,
   output reg [NW-1:0] quo_o
);
   reg [DW-1:0] den_r;
   reg [DW:0] rem_r;
   reg [5:0] cnt_r;
   wire [DW:0] trial = {rem_r[DW-1:0], quo_o[NW-1]};

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         quo_o <= {NW{1'b0}};
         den_r <= {DW{1'b0}};
         rem_r <= {(DW+1){1'b0}};
         cnt_r <= 6'h00;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i && !busy_o)
         begin
            busy_o <= 1'b1;
            quo_o <= num_i;
            den_r <= den_i;
            rem_r <= {(DW+1){1'b0}};
            cnt_r <= NW[5:0];
         end
         else if (busy_o)
         begin
            // A zero divisor yields all ones, read later as saturation.
            if (trial >= {1'b0, den_r})
            begin
               rem_r <= trial - {1'b0, den_r};
               quo_o <= {quo_o[NW-2:0], 1'b1};
            end
            else
            begin
               rem_r <= trial;
               quo_o <= {quo_o[NW-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule

// File: msv_supervisor.v
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "msv_defines.vh"
module msv_supervisor #(
   parameter VARIANT = 0,
   parameter TICK_CYC = `MSV_TICK_CYC,
   parameter SETTLE_MS = `MSV_SETTLE_MS
)(
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [7:0] speed_i,
   input wire [7:0] duty_i,
   input wire [15:0] batt_mv_i,
   input wire [15:0] mot_mv_i,
   input wire [15:0] mot_ma_i,
   input wire brake_req_i,
   output reg brake_rel_o,
   output reg test_active_o,
   output reg [16:0] cur_lim_ma_o,
   output reg [7:0] duty_cap_o,
   output reg [9:0] res_comp_o,
   output reg stall_fault_o,
   output reg irq_o
);
   localparam [6:0] RATE_MAX = (VARIANT == 1) ? `MSV_RATE_V1 :
      (VARIANT == 2) ? `MSV_RATE_V2 : `MSV_RATE_V0;
   localparam [1:0] R_IDLE = 2'h0;
   localparam [1:0] R_SETTLE = 2'h1;
   localparam [1:0] R_MEAS = 2'h2;
   localparam [1:0] R_REL = 2'h3;

   reg auto_r;
   reg [9:0] sysres_r;
   reg [5:0] testpct_r;
   reg [4:0] vmax_r;
   reg [6:0] rating_r;
   reg [6:0] maxt_r;
   reg [6:0] cbgain_r;
   reg [7:0] stspeed_r;
   reg [6:0] stduty_r;
   reg [5:0] sttime_r;
   reg [6:0] mainlim_r;
   reg [2:0] status_r;
   reg [2:0] mask_r;
   reg [9:0] meas_r;
   reg [1:0] rstate_r;
   reg [16:0] tick_cnt_r;
   reg tick_r;
   reg [15:0] stall_ms_r;
   reg [16:0] atlim_ms_r;
   reg cutback_r;
   reg [16:0] cb_lim_r;
   reg [15:0] settle_r;
   reg div_go_r;
   reg job_res_r;
   reg [2:0] w1c;

   wire div_busy;
   wire div_done;
   wire [25:0] div_quo;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];

   // Clamp a written value into its accepted range.
   function [9:0] clampf;
      input [31:0] v;
      input [9:0] lo;
      input [9:0] hi;
      begin
         if (v < {22'h000000, lo})
            clampf = lo;
         else if (v > {22'h000000, hi})
            clampf = hi;
         else
            clampf = v[9:0];
      end
   endfunction

   wire [16:0] main_ma = mainlim_r * 17'd1000;
   wire [16:0] rate_ma = rating_r * 17'd1000;
   wire [16:0] test_ma = mainlim_r * testpct_r * 17'd10;
   wire [16:0] cb_step = cbgain_r * `MSV_CB_STEP_MA;
   wire at_limit = {1'b0, mot_ma_i} >= main_ma;
   wire [16:0] maxt_ms = maxt_r * 17'd1000;
   wire [15:0] sttime_ms = sttime_r * 16'd1000;
   // Duty below threshold: duty/255 < pct/100, kept in integers.
   wire duty_low = (duty_i * 15'd100) < (stduty_r * 15'd255);
   wire speed_low = speed_i < stspeed_r;
   wire stall_cond = duty_low & speed_low;
   // Event strobes are combinational so status sees them at the same edge.
   wire ev_stall = tick_r & stall_cond & (stall_ms_r == sttime_ms);
   wire ev_maxt = tick_r & at_limit & ~cutback_r
      & (atlim_ms_r + 17'h00001 >= maxt_ms);
   wire ev_rdone = (rstate_r == R_MEAS) & div_done & job_res_r;
   wire [25:0] duty_num = vmax_r * 26'd255000;
   wire [25:0] res_num = mot_mv_i * 26'd1000;
   wire [9:0] cl_test = clampf(wb_dat_i, `MSV_TEST_MIN, `MSV_TEST_MAX);
   wire [9:0] cl_vmax = clampf(wb_dat_i, `MSV_VMAX_MIN, `MSV_VMAX_MAX);
   wire [9:0] cl_rate = clampf(wb_dat_i, 10'd0, {3'h0, RATE_MAX});
   wire [9:0] cl_maxt = clampf(wb_dat_i, 10'd0, `MSV_MAXT_MAX);
   wire [9:0] cl_pct = clampf(wb_dat_i, 10'd0, `MSV_PCT_MAX);
   wire [9:0] cl_stt = clampf(wb_dat_i, `MSV_STT_MIN, `MSV_STT_MAX);

   // Register writes; CTRL, STSPEED, MAINLIM and MASK take their low bits unclamped, the rest are clamped to their accepted ranges.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         auto_r <= 1'b0;
         sysres_r <= `MSV_RST_RES;
         testpct_r <= `MSV_RST_TEST;
         vmax_r <= `MSV_RST_VMAX;
         rating_r <= `MSV_RST_RATING;
         maxt_r <= `MSV_RST_MAXT;
         cbgain_r <= `MSV_RST_CBGAIN;
         stspeed_r <= `MSV_RST_STSPEED;
         stduty_r <= `MSV_RST_STDUTY;
         sttime_r <= `MSV_RST_STTIME;
         mainlim_r <= `MSV_RST_MAINLIM;
         mask_r <= 3'h0;
      end
      else if (wb_wr)
      begin
         if (wb_adr_i == `MSV_CTRL)
            auto_r <= wb_dat_i[`MSV_CTRL_AUTO];
         else if (wb_adr_i == `MSV_SYSRES)
            sysres_r <= clampf(wb_dat_i, 10'd0, `MSV_RES_MAX);
         else if (wb_adr_i == `MSV_TESTPCT)
            testpct_r <= cl_test[5:0];
         else if (wb_adr_i == `MSV_VMAX)
            vmax_r <= cl_vmax[4:0];
         else if (wb_adr_i == `MSV_RATING)
            rating_r <= cl_rate[6:0];
         else if (wb_adr_i == `MSV_MAXTIME)
            maxt_r <= cl_maxt[6:0];
         else if (wb_adr_i == `MSV_CBGAIN)
            cbgain_r <= cl_pct[6:0];
         else if (wb_adr_i == `MSV_STSPEED)
            stspeed_r <= wb_dat_i[7:0];
         else if (wb_adr_i == `MSV_STDUTY)
            stduty_r <= cl_pct[6:0];
         else if (wb_adr_i == `MSV_STTIME)
            sttime_r <= cl_stt[5:0];
         else if (wb_adr_i == `MSV_MAINLIM)
            mainlim_r <= wb_dat_i[6:0];
         else if (wb_adr_i == `MSV_MASK)
            mask_r <= wb_dat_i[2:0];
      end
   end

   // Read path and single-cycle acknowledge; unmapped reads give zero.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_adr_i == `MSV_CTRL)
            wb_dat_o <= {31'h0, auto_r};
         else if (wb_adr_i == `MSV_SYSRES)
            wb_dat_o <= {22'h0, sysres_r};
         else if (wb_adr_i == `MSV_TESTPCT)
            wb_dat_o <= {26'h0, testpct_r};
         else if (wb_adr_i == `MSV_VMAX)
            wb_dat_o <= {27'h0, vmax_r};
         else if (wb_adr_i == `MSV_RATING)
            wb_dat_o <= {25'h0, rating_r};
         else if (wb_adr_i == `MSV_MAXTIME)
            wb_dat_o <= {25'h0, maxt_r};
         else if (wb_adr_i == `MSV_CBGAIN)
            wb_dat_o <= {25'h0, cbgain_r};
         else if (wb_adr_i == `MSV_STSPEED)
            wb_dat_o <= {24'h0, stspeed_r};
         else if (wb_adr_i == `MSV_STDUTY)
            wb_dat_o <= {25'h0, stduty_r};
         else if (wb_adr_i == `MSV_STTIME)
            wb_dat_o <= {26'h0, sttime_r};
         else if (wb_adr_i == `MSV_MAINLIM)
            wb_dat_o <= {25'h0, mainlim_r};
         else if (wb_adr_i == `MSV_STATUS)
            wb_dat_o <= {29'h0, status_r};
         else if (wb_adr_i == `MSV_MASK)
            wb_dat_o <= {29'h0, mask_r};
         else if (wb_adr_i == `MSV_STATE)
            wb_dat_o <= {16'h0, cutback_r, rstate_r, 3'h0, meas_r};
         else
            wb_dat_o <= 32'h00000000;
      end
   end

   // Millisecond tick shared by every timer.
   always @(posedge clk_i)
   begin
      if (rst_i || tick_cnt_r == TICK_CYC - 1)
         tick_cnt_r <= 17'h00000;
      else
         tick_cnt_r <= tick_cnt_r + 17'h00001;
      tick_r <= !rst_i && (tick_cnt_r == TICK_CYC - 1);
   end

   // Stall persistence timer; the fault needs strictly more than the timeout.
   always @(posedge clk_i)
   begin
      if (rst_i || !stall_cond)
         stall_ms_r <= 16'h0000;
      else if (tick_r && stall_ms_r <= sttime_ms)
         stall_ms_r <= stall_ms_r + 16'h0001;
   end

   // Time at main limit, then ramp down toward the rating.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         atlim_ms_r <= 17'h00000;
         cutback_r <= 1'b0;
         cb_lim_r <= 17'h00000;
      end
      else if (!cutback_r)
      begin
         cb_lim_r <= main_ma;
         if (!at_limit)
            atlim_ms_r <= 17'h00000;
         else if (tick_r)
         begin
            atlim_ms_r <= atlim_ms_r + 17'h00001;
            if (ev_maxt)
               cutback_r <= 1'b1;
         end
      end
      else if (tick_r)
      begin
         // Cutback holds until reset; the stage has no cooling model.
         if (cb_lim_r <= rate_ma + cb_step)
            cb_lim_r <= rate_ma;
         else
            cb_lim_r <= cb_lim_r - cb_step;
      end
   end

   // Resistance test before brake release.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rstate_r <= R_IDLE;
         settle_r <= 16'h0000;
         meas_r <= 10'h000;
      end
      else
      begin
         case (rstate_r)
            R_IDLE:
               if (brake_req_i)
               begin
                  settle_r <= 16'h0000;
                  rstate_r <= auto_r ? R_SETTLE : R_REL;
               end
            R_SETTLE:
               if (tick_r)
               begin
                  settle_r <= settle_r + 16'h0001;
                  if (settle_r == SETTLE_MS - 1)
                     rstate_r <= R_MEAS;
               end
            R_MEAS:
               if (div_done && job_res_r)
               begin
                  meas_r <= clampf({6'h0, div_quo}, 10'd0,
                     `MSV_RES_MAX) ;
                  rstate_r <= R_REL;
               end
            default:
               if (!brake_req_i)
                  rstate_r <= R_IDLE;
         endcase
      end
   end

   // One divider shared between the duty ceiling and the resistance test.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_go_r <= 1'b0;
         job_res_r <= 1'b0;
      end
      else
      begin
         div_go_r <= !div_busy && !div_go_r && !div_done;
         if (!div_busy && !div_go_r && !div_done)
            job_res_r <= (rstate_r == R_MEAS);
      end
   end

   msv_div #(
      .NW(26),
      .DW(16)
   ) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(div_go_r),
      .num_i(job_res_r ? res_num : duty_num),
      .den_i(job_res_r ? mot_ma_i : batt_mv_i),
      .busy_o(div_busy),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   // Status flags: a new event wins over a write-one-to-clear.
   always @*
   begin
      w1c = (wb_wr && wb_adr_i == `MSV_STATUS) ? wb_dat_i[2:0] : 3'h0;
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status_r <= 3'h0;
         irq_o <= 1'b0;
         stall_fault_o <= 1'b0;
         brake_rel_o <= 1'b0;
         test_active_o <= 1'b0;
         cur_lim_ma_o <= 17'h00000;
         duty_cap_o <= 8'hff;
         res_comp_o <= 10'h000;
      end
      else
      begin
         status_r <= (status_r & ~w1c) | {ev_rdone, ev_maxt, ev_stall};
         irq_o <= |(status_r & mask_r);
         stall_fault_o <= status_r[`MSV_ST_STALL];
         brake_rel_o <= (rstate_r == R_REL) && brake_req_i;
         test_active_o <= (rstate_r == R_SETTLE) || (rstate_r == R_MEAS);
         if (rstate_r == R_SETTLE || rstate_r == R_MEAS)
            cur_lim_ma_o <= test_ma;
         else
            cur_lim_ma_o <= cb_lim_r;
         if (div_done && !job_res_r)
            duty_cap_o <= (div_quo > 26'd255) ? 8'hff : div_quo[7:0];
         res_comp_o <= auto_r ? meas_r : sysres_r;
      end
   end
endmodule

// File: msv_checker.sv
`timescale 1ns/100ps
module msv_checker #(
   parameter TICK_CYC = 100000
)(
   input logic clk_i,
   input logic rst_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [5:0] wb_adr_i,
   input logic [31:0] wb_dat_i,
   input logic wb_ack_o,
   input logic [7:0] speed_i,
   input logic [7:0] duty_i,
   input logic brake_req_i,
   input logic brake_rel_o,
   input logic test_active_o,
   input logic [16:0] cur_lim_ma_o,
   input logic [7:0] duty_cap_o,
   input logic stall_fault_o,
   input logic irq_o
);
   localparam int STALL_MIN = 15999 * TICK_CYC;
   logic [31:0] low_run_r;
   logic [31:0] low_run_nxt;
   // Both thresholds compare strictly, so a full-scale sample is never low and ends a stall.
   always @*
   begin
      low_run_nxt = low_run_r;
      if (speed_i == 8'hff || duty_i == 8'hff)
         low_run_nxt = 32'h0;
      else if (low_run_r != 32'hffffffff)
         low_run_nxt = low_run_r + 32'h1;
   end
   always @(posedge clk_i)
   begin
      if (rst_i)
         low_run_r <= 32'h0;
      else
         low_run_r <= low_run_nxt;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing one cycle after request");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   reset_outs_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
      && !brake_rel_o && !test_active_o && !stall_fault_o && !irq_o
      && duty_cap_o == 8'hff) else $error("outputs wrong after reset");
   brake_gate_a: assert property (brake_rel_o |-> $past(brake_req_i))
      else $error("brake released without request");
   test_excl_a: assert property (test_active_o |-> !brake_rel_o)
      else $error("brake released during resistance test");
   stall_len_a: assert property ($rose(stall_fault_o)
      |-> low_run_r >= STALL_MIN) else $error("stall fault before timeout");
   fault_clear_a: assert property ($fell(stall_fault_o)
      |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == 6'h2c && wb_dat_i[0], 2))
      else $error("stall fault dropped without clear");
   cut_rate_a: assert property (!test_active_o && !$past(test_active_o)
      && !$past(test_active_o, 2) && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2)
      && !$past(wb_cyc_i, 3) && $past(brake_req_i, 3) == brake_req_i
      |-> {1'b0, cur_lim_ma_o} + 18'h64 >= {1'b0, $past(cur_lim_ma_o)})
      else $error("current limit fell too fast");
   cover property ($rose(stall_fault_o));
   cover property ($rose(test_active_o));
   cover property ($rose(brake_rel_o));
   cover property ($fell(irq_o));
endmodule
bind msv_supervisor msv_checker #(.TICK_CYC(TICK_CYC)) msv_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .speed_i(speed_i), .duty_i(duty_i),
   .brake_req_i(brake_req_i), .brake_rel_o(brake_rel_o),
   .test_active_o(test_active_o), .cur_lim_ma_o(cur_lim_ma_o),
   .duty_cap_o(duty_cap_o), .stall_fault_o(stall_fault_o), .irq_o(irq_o));

// File: msv_stage_model.sv
`timescale 1ns/100ps
module msv_stage_model #(
   parameter R_MOHM = 250
)(
   input logic clk_i,
   input logic [16:0] cur_lim_ma_i,
   input logic [7:0] duty_cap_i,
   input logic [16:0] demand_ma_i,
   input logic [7:0] duty_cmd_i,
   input logic moving_i,
   output logic [7:0] speed_o,
   output logic [7:0] duty_o,
   output logic [15:0] mot_ma_o,
   output logic [15:0] mot_mv_o
);
   logic [16:0] ma;
   logic [7:0] dc;
   // The stage draws what the load asks, but never above the limit given.
   assign ma = (demand_ma_i < cur_lim_ma_i) ? demand_ma_i : cur_lim_ma_i;
   assign dc = (duty_cmd_i < duty_cap_i) ? duty_cmd_i : duty_cap_i;
   always @(posedge clk_i)
   begin
      mot_ma_o <= ma[15:0];
      mot_mv_o <= 16'((32'(ma) * R_MOHM) / 32'h3e8);
      duty_o <= dc;
      // A blocked rotor reports no speed whatever the duty.
      speed_o <= moving_i ? dc : 8'h0;
   end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, brq = 0, mov = 0;
   logic ack, rel, tact, stall, irq;
   logic [5:0] adr = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic [15:0] batt = 16'h7530, ma, mv;
   logic [16:0] dem = 0, lim;
   logic [7:0] dcmd = 8'h14, spd, duty, cap;
   logic [9:0] rc;
   logic [6:0] rv [14] = '{7'h0, 7'h0, 7'ha, 7'h18, 7'h0, 7'h3c, 7'h32,
      7'h0, 7'h0, 7'h10, 7'h2d, 7'h0, 7'h0, 7'h0};
   logic [5:0] ta [13] = '{6'h04, 6'h08, 6'h08, 6'h0c, 6'h0c, 6'h10, 6'h14,
      6'h18, 6'h1c, 6'h20, 6'h24, 6'h24, 6'h3c};
   logic [9:0] tw [13] = '{10'h384, 10'h2, 10'h3c, 10'h1e, 10'ha, 10'h64,
      10'hc8, 10'h96, 10'hff, 10'h65, 10'h28, 10'h3, 10'h5};
   logic [9:0] te [13] = '{10'h320, 10'h5, 10'h32, 10'h1b, 10'h14, 10'h2d,
      10'h78, 10'h64, 10'hff, 10'h64, 10'h20, 10'h10, 10'h0};
   int errors = 0, checked = 0, cyc_n = 0, n, i;
   always #5 clk_i = ~clk_i;
   msv_supervisor #(.TICK_CYC(2), .SETTLE_MS(2)) msv_supervisor_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .speed_i(spd), .duty_i(duty),
      .batt_mv_i(batt), .mot_mv_i(mv), .mot_ma_i(ma), .brake_req_i(brq),
      .brake_rel_o(rel), .test_active_o(tact), .cur_lim_ma_o(lim),
      .duty_cap_o(cap), .res_comp_o(rc), .stall_fault_o(stall), .irq_o(irq));
   msv_stage_model msv_stage_model_inst (.clk_i(clk_i), .cur_lim_ma_i(lim),
      .duty_cap_i(cap), .demand_ma_i(dem), .duty_cmd_i(dcmd),
      .moving_i(mov), .speed_o(spd), .duty_o(duty), .mot_ma_o(ma),
      .mot_mv_o(mv));
   task tally_and_finish;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      bus(1, a, d);
   endtask
   task rdc(input logic [5:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task cyc_wait(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 90000)
      begin
         errors++;
         tally_and_finish;
      end
   end
   initial
   begin
      cyc_wait(20);
      rst_i <= 0;
      for (i = 0; i < 14; i++)
         rdc(6'(i * 4), rv[i]);
      for (i = 0; i < 13; i++)
      begin
         wr(ta[i], tw[i]);
         rdc(ta[i], te[i]);
      end
      wr(6'h1c, 0);
      wr(6'h0c, 24);
      cyc_wait(100);
      chk("cap", 8'hcc, cap);
      batt <= 16'h4e20;
      cyc_wait(100);
      chk("cap", 8'hff, cap);
      wr(6'h04, 10'h12c);
      brq <= 1;
      n = 0;
      while (rel !== 1'b1 && n < 50) begin cyc_wait(1); n++; end
      chk("rc", 10'h12c, rc);
      brq <= 0;
      wr(6'h00, 1);
      wr(6'h08, 20);
      dem <= 17'hea60;
      brq <= 1;
      n = 0;
      while (tact !== 1'b1 && n < 20) begin cyc_wait(1); n++; end
      cyc_wait(3);
      chk("lim", 17'h2328, lim);
      n = 0;
      while (rel !== 1'b1 && n < 500) begin cyc_wait(1); n++; end
      chk("rc", 10'hfa, rc);
      rdc(6'h34, 32'h60fa);
      rdc(6'h2c, 4);
      wr(6'h2c, 4);
      rdc(6'h2c, 0);
      brq <= 0;
      wr(6'h10, 40);
      wr(6'h18, 100);
      wr(6'h14, 1);
      wr(6'h30, 2);
      n = 0;
      while (irq !== 1'b1 && n < 2500) begin cyc_wait(1); n++; end
      chk("irq", 1, irq);
      cyc_wait(400);
      chk("lim", 17'h9c40, lim);
      bus(0, 6'h34, 0);
      chk("cut", 1, q[15]);
      rdc(6'h2c, 2);
      wr(6'h2c, 2);
      cyc_wait(2);
      chk("irq", 0, irq);
      dem <= 0;
      wr(6'h1c, 10);
      wr(6'h20, 50);
      cyc_wait(30000);
      chk("stall", 0, stall);
      mov <= 1;
      cyc_wait(10);
      mov <= 0;
      cyc_wait(31900);
      chk("stall", 0, stall);
      n = 0;
      while (stall !== 1'b1 && n < 400) begin cyc_wait(1); n++; end
      chk("stall", 1, stall);
      chk("irq", 0, irq);
      wr(6'h30, 1);
      cyc_wait(2);
      chk("irq", 1, irq);
      mov <= 1;
      wr(6'h2c, 1);
      cyc_wait(3);
      chk("stall", 0, stall);
      chk("irq", 0, irq);
      tally_and_finish;
   end
endmodule
